//--- core/smd_top.sv
`timescale 1ns/1ps
// What this block does
// - Architecture bit clear selects hybrid layout, set selects uniform layout.
// - Parameter-location bit clear puts small sectors low, set puts them high.
// - Uniform-size bit clear selects 64 KB sectors, set selects 256 KB.
// - Index 00h is small sectors bottom, 02h top, rest 64 KB.
// - Index 01h is small sectors bottom, 03h top, rest 256 KB.
// - Descriptors name read-any-register; host fetches configuration bytes with it.
// - First two descriptors have end flag and command-descriptor bit cleared.
// - Third descriptor has end flag set and a bit 1 mask.
module smd_top #(
    parameter int ADDR_BITS = smd_pkg::SMD_DEF_ADDR_BITS,
    parameter int LATENCY = smd_pkg::SMD_DEF_LATENCY
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    output logic [2:0] sector_map_index,
    output logic sector_map_valid
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (ADDR_BITS != 24 && ADDR_BITS != 32) begin : g_bad_addr
        $error("ADDR_BITS must be 24 or 32");
    end
    if (LATENCY < 0 || LATENCY > 15) begin : g_bad_lat
        $error("LATENCY must be 0 to 15");
    end

    // ==========================================================
    // Link input synchronisation and edge detection
    // ==========================================================
    smd_pkg::smd_link_in_t link_raw;
    smd_pkg::smd_link_in_t link_s;
    logic sclk_prev_q;
    logic sclk_rise;
    logic sclk_fall;

    assign link_raw = '{sclk: spi_sclk, cs_n: spi_cs_n, mosi: spi_mosi};

    smd_sync #(.WIDTH(smd_pkg::SMD_LINK_W)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(link_raw),
        .sync_out(link_s)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclk_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= link_s.sclk;
        end
    end

    assign sclk_rise = link_s.sclk & ~sclk_prev_q & ~link_s.cs_n;
    assign sclk_fall = ~link_s.sclk & sclk_prev_q & ~link_s.cs_n;

    // ==========================================================
    // Configuration registers, cleared by reset
    // ==========================================================
    logic [7:0] config_one_q;
    logic [7:0] config_three_q;
    logic wb_req;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            config_one_q <= smd_pkg::SMD_CONFIG_ONE_RST;
            config_three_q <= smd_pkg::SMD_CONFIG_THREE_RST;
        end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == smd_pkg::SMD_WB_CONFIG_ONE) begin
                config_one_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == smd_pkg::SMD_WB_CONFIG_THREE) begin
                config_three_q <= wb_dat_i[7:0];
            end
        end
    end

    // ==========================================================
    // Sector map decode
    // ==========================================================
    logic arch_uniform;
    logic param_top;
    logic size_256k;
    logic [2:0] map_d;

    assign arch_uniform = config_three_q[smd_pkg::SMD_ARCH_BIT];
    assign param_top = config_one_q[smd_pkg::SMD_PLOC_BIT];
    assign size_256k = config_three_q[smd_pkg::SMD_USIZE_BIT];

    always_comb begin
        if (arch_uniform) begin
            map_d = size_256k ? smd_pkg::SMD_MAP_UNIFORM_256K
                              : smd_pkg::SMD_MAP_UNIFORM_64K;
        end else begin
            map_d = {1'b0, param_top, size_256k};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sector_map_index <= 3'h0;
            sector_map_valid <= 1'b1;
        end else begin
            sector_map_index <= map_d;
            sector_map_valid <= ~(arch_uniform & param_top);
        end
    end

    // ==========================================================
    // Link byte lookup
    // ==========================================================
    function automatic logic [7:0] lookup(input logic [31:0] addr, input logic sfdp,
                                          input logic [7:0] c1, input logic [7:0] c3);
        logic [31:0] rel;
        rel = addr - smd_pkg::SMD_DESC_BASE;
        if (sfdp) begin
            if (addr >= smd_pkg::SMD_DESC_BASE && rel < 32'(smd_pkg::SMD_DESC_BYTES)) begin
                lookup = smd_pkg::SMD_DESC_ROM[rel[4:0]*8 +: 8];
            end else begin
                lookup = smd_pkg::SMD_SFDP_BLANK;
            end
        end else if (addr == smd_pkg::SMD_LREG_CONFIG_THREE) begin
            lookup = c3;
        end else if (addr == smd_pkg::SMD_LREG_CONFIG_ONE) begin
            lookup = c1;
        end else begin
            lookup = 8'h00;
        end
    endfunction : lookup

    // ==========================================================
    // Link command engine
    // ==========================================================
    smd_pkg::smd_state_t state_q;
    logic [5:0] cnt_q;
    logic [31:0] shift_q;
    logic [31:0] addr_q;
    logic is_sfdp_q;
    logic [7:0] out_q;
    logic [5:0] addr_last;
    logic [5:0] dummy_last;
    logic [31:0] addr_in;

    assign addr_last = is_sfdp_q ? 6'(smd_pkg::SMD_SFDP_ADDR_BITS - 1) : 6'(ADDR_BITS - 1);
    assign dummy_last = is_sfdp_q ? 6'(smd_pkg::SMD_SFDP_DUMMY - 1) : 6'(LATENCY - 1);
    assign addr_in = {shift_q[30:0], link_s.mosi};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= smd_pkg::SMD_ST_CMD;
            cnt_q <= 6'h00;
            shift_q <= 32'h0000_0000;
            addr_q <= 32'h0000_0000;
            is_sfdp_q <= 1'b0;
            out_q <= 8'h00;
        end else if (link_s.cs_n) begin
            state_q <= smd_pkg::SMD_ST_CMD;
            cnt_q <= 6'h00;
            is_sfdp_q <= 1'b0;
        end else begin
            unique case (state_q)
                smd_pkg::SMD_ST_CMD: begin
                    if (sclk_rise) begin
                        shift_q <= addr_in;
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'd7) begin
                            cnt_q <= 6'h00;
                            shift_q <= 32'h0000_0000;
                            if (addr_in[7:0] == smd_pkg::SMD_CMD_READ_ANY_REG) begin
                                state_q <= smd_pkg::SMD_ST_ADDR;
                            end else if (addr_in[7:0] == smd_pkg::SMD_CMD_READ_SFDP) begin
                                state_q <= smd_pkg::SMD_ST_ADDR;
                                is_sfdp_q <= 1'b1;
                            end else begin
                                state_q <= smd_pkg::SMD_ST_IGNORE;
                            end
                        end
                    end
                end
                smd_pkg::SMD_ST_ADDR: begin
                    if (sclk_rise) begin
                        shift_q <= addr_in;
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == addr_last) begin
                            cnt_q <= 6'h00;
                            addr_q <= addr_in;
                            if (!is_sfdp_q && LATENCY == 0) begin
                                state_q <= smd_pkg::SMD_ST_DATA;
                                out_q <= lookup(addr_in, 1'b0, config_one_q, config_three_q);
                            end else begin
                                state_q <= smd_pkg::SMD_ST_DUMMY;
                            end
                        end
                    end
                end
                smd_pkg::SMD_ST_DUMMY: begin
                    if (sclk_rise) begin
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == dummy_last) begin
                            cnt_q <= 6'h00;
                            state_q <= smd_pkg::SMD_ST_DATA;
                            out_q <= lookup(addr_q, is_sfdp_q, config_one_q, config_three_q);
                        end
                    end
                end
                smd_pkg::SMD_ST_DATA: begin
                    if (sclk_fall) begin
                        out_q <= {out_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'd7) begin
                            cnt_q <= 6'h00;
                            addr_q <= addr_q + 32'h0000_0001;
                            out_q <= lookup(addr_q + 32'h0000_0001, is_sfdp_q,
                                            config_one_q, config_three_q);
                        end
                    end
                end
                smd_pkg::SMD_ST_IGNORE: begin
                    cnt_q <= 6'h00;
                end
                default: begin
                    state_q <= smd_pkg::SMD_ST_IGNORE;
                end
            endcase
        end
    end

    // ==========================================================
    // Serial output driver
    // ==========================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spi_miso_o <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else if (link_s.cs_n) begin
            spi_miso_oe <= 1'b0;
        end else if (sclk_fall && state_q == smd_pkg::SMD_ST_DATA) begin
            spi_miso_o <= out_q[7];
            spi_miso_oe <= 1'b1;
        end
    end

    // ==========================================================
    // Wishbone slave
    // ==========================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    smd_pkg::SMD_WB_CONFIG_ONE: wb_dat_o <= {24'h00_0000, config_one_q};
                    smd_pkg::SMD_WB_CONFIG_THREE: wb_dat_o <= {24'h00_0000, config_three_q};
                    smd_pkg::SMD_WB_STATUS: begin
                        wb_dat_o <= {27'h000_0000, ~link_s.cs_n, sector_map_valid,
                                     sector_map_index};
                    end
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : smd_top

//--- core/smd_pkg.sv
package smd_pkg;

    // ==========================================================
    // Link pins
    // ==========================================================
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } smd_link_in_t;

    localparam int SMD_LINK_W = 3;

    // ==========================================================
    // Link commands and timing
    // ==========================================================
    localparam logic [7:0] SMD_CMD_READ_ANY_REG = 8'h65;
    localparam logic [7:0] SMD_CMD_READ_SFDP = 8'h5a;
    localparam int SMD_SFDP_ADDR_BITS = 24;
    localparam int SMD_SFDP_DUMMY = 8;
    localparam int SMD_DEF_ADDR_BITS = 24;
    localparam int SMD_DEF_LATENCY = 8;

    // ==========================================================
    // Device register addresses on the link
    // ==========================================================
    localparam logic [31:0] SMD_LREG_CONFIG_ONE = 32'h0000_0002;
    localparam logic [31:0] SMD_LREG_CONFIG_THREE = 32'h0000_0004;

    // ==========================================================
    // Configuration bit positions
    // ==========================================================
    localparam int SMD_ARCH_BIT = 3;
    localparam int SMD_USIZE_BIT = 1;
    localparam int SMD_PLOC_BIT = 2;
    localparam logic [7:0] SMD_CONFIG_ONE_RST = 8'h00;
    localparam logic [7:0] SMD_CONFIG_THREE_RST = 8'h00;

    // ==========================================================
    // Sector map indices
    // ==========================================================
    localparam logic [2:0] SMD_MAP_UNIFORM_64K = 3'h4;
    localparam logic [2:0] SMD_MAP_UNIFORM_256K = 3'h5;

    // ==========================================================
    // Detection descriptor table
    // ==========================================================
    localparam logic [31:0] SMD_DESC_BASE = 32'h0000_0048;
    localparam int SMD_DESC_BYTES = 24;
    localparam logic [7:0] SMD_SFDP_BLANK = 8'hff;
    localparam logic [SMD_DESC_BYTES*8-1:0] SMD_DESC_ROM = {
        8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'hff, 8'h65, 8'hfd,
        8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'hff, 8'h65, 8'hfc,
        8'h00, 8'h00, 8'h00, 8'h04, 8'h08, 8'hff, 8'h65, 8'hfc
    };

    // ==========================================================
    // Wishbone register map
    // ==========================================================
    localparam logic [3:0] SMD_WB_CONFIG_ONE = 4'h0;
    localparam logic [3:0] SMD_WB_CONFIG_THREE = 4'h4;
    localparam logic [3:0] SMD_WB_STATUS = 4'h8;
    localparam int SMD_ST_VALID_BIT = 3;
    localparam int SMD_ST_BUSY_BIT = 4;

    typedef enum logic [2:0] {
        SMD_ST_CMD,
        SMD_ST_ADDR,
        SMD_ST_DUMMY,
        SMD_ST_DATA,
        SMD_ST_IGNORE
    } smd_state_t;

endpackage : smd_pkg

//--- core/smd_sync.sv
`timescale 1ns/1ps
module smd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Two-stage synchroniser per bit
    // ==========================================================
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_q;
        logic sync_q;
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                meta_q <= 1'b1;
                sync_q <= 1'b1;
            end else begin
                meta_q <= async_in[i];
                sync_q <= meta_q;
            end
        end
        assign sync_out[i] = sync_q;
    end

endmodule : smd_sync

//--- testbench/smd_top_asserts.sv
`timescale 1ns/1ps
module smd_top_asserts #(
    parameter int ADDR_BITS = 24,
    parameter int LATENCY = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe,
    input wire logic [2:0] sector_map_index,
    input wire logic sector_map_valid
);
    // ====================
    // Port properties.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without strobe");
    a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data changed outside a read");
    a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && wb_adr_i == 4'hc |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_oe_idle: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
        else $error("output enabled while deselected");
    a_oe_select: assert property ($rose(spi_miso_oe) |-> !spi_cs_n && !$past(spi_cs_n, 3))
        else $error("output enabled without select");
    a_uniform_index: assert property (sector_map_index[2] |-> !sector_map_index[1])
        else $error("uniform index out of range");
    a_invalid_arch: assert property (!sector_map_valid |-> sector_map_index[2])
        else $error("hybrid index flagged invalid");
    a_index_cause: assert property ($changed(sector_map_index) |->
        $past(wb_we_i) || $past(wb_we_i, 2))
        else $error("index changed without a write");
endmodule : smd_top_asserts

bind smd_top smd_top_asserts #(.ADDR_BITS(ADDR_BITS), .LATENCY(LATENCY)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .sector_map_index(sector_map_index), .sector_map_valid(sector_map_valid));

//--- testbench/smd_host_model.sv
`timescale 1ns/1ps
module smd_host_model #(
    parameter int ADDR_BITS = 24,
    parameter int LATENCY = 8
) (
    input wire logic ref_clk,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi
);
    // ====================
    // Link master, mode 0, clock still between frames.
    initial begin
        spi_sclk = 1'h0;
        spi_cs_n = 1'h1;
        spi_mosi = 1'h0;
    end
    task automatic bit_io(input logic b, output logic r);
        spi_mosi <= b;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        r = spi_miso_oe ? spi_miso_o : ~spi_miso_o;
        @(posedge ref_clk);
        spi_sclk <= 1'h1;
        repeat (4) @(posedge ref_clk);
        spi_sclk <= 1'h0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] adr, input int abits,
                        input int dum, input int nb, output logic [191:0] rd);
        logic r;
        rd = '0;
        spi_cs_n <= 1'h0;
        repeat (4) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--) bit_io(cmd[i], r);
        for (int i = abits - 1; i >= 0; i--) bit_io(adr[i], r);
        for (int i = 0; i < dum; i++) bit_io(1'h1, r);
        for (int i = 0; i < nb * 8; i++) begin
            bit_io(1'h0, r);
            rd = {rd[190:0], r};
        end
        repeat (4) @(posedge ref_clk);
        spi_cs_n <= 1'h1;
        spi_mosi <= ~spi_mosi;
        repeat (8) @(posedge ref_clk);
    endtask : xfer
    task automatic detect(output logic [2:0] idx, output int n);
        logic [191:0] d;
        logic [191:0] v;
        logic fin;
        idx = '0;
        n = 0;
        fin = 1'h0;
        while (!fin && n < 4) begin
            xfer(smd_pkg::SMD_CMD_READ_SFDP, 32'h0000_0048 + 32'(n * 8), 24, 8, 8, d);
            xfer(d[55:48], {d[7:0], d[15:8], d[23:16], d[31:24]}, ADDR_BITS, LATENCY, 1,
                 v);
            idx = {idx[1:0], |(v[7:0] & d[39:32])};
            fin = d[56];
            n++;
        end
    endtask : detect
endmodule : smd_host_model

//--- testbench/test_sector_map_detection.sv
`timescale 1ns/1ps
module test_sector_map_detection;
    localparam logic [191:0] DESC_EXP =
        192'hfc65_ff08_0400_0000_fc65_ff04_0200_0000_fd65_ff02_0400_0000;
    logic ref_clk;
    logic rst;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [3:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic spi_sclk;
    logic spi_cs_n;
    logic spi_mosi;
    logic spi_miso_o;
    logic spi_miso_oe;
    logic [2:0] sector_map_index;
    logic sector_map_valid;
    logic [2:0] idx;
    logic [31:0] rd;
    logic [191:0] q;
    logic a;
    logic p;
    logic u;
    int oe_cnt = 0;
    int n0;
    int n;
    int n_fail;
    int compares;
    smd_top #(.ADDR_BITS(32), .LATENCY(4)) dut (
        .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
        .sector_map_index(sector_map_index), .sector_map_valid(sector_map_valid));
    smd_host_model #(.ADDR_BITS(32), .LATENCY(4)) host (
        .ref_clk(ref_clk), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
    // ====================
    // Shared tasks.
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                      input logic [3:0] sel, output logic [31:0] rd_o);
        int k;
        k = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack_o !== 1'h1 && k < 20);
        if (wb_ack_o !== 1'h1) begin
            n_fail++;
            conclude();
        end
        rd_o = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge ref_clk);
    endtask : wb
    // ====================
    // Clock and main sequence.
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (spi_miso_oe === 1'h1) oe_cnt <= oe_cnt + 1;
    initial begin
        rst = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        n_fail = 0;
        compares = 0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        repeat (4) @(posedge ref_clk);
        wb(1'h0, 4'h8, 32'h0, 4'hf, rd);
        chk(rd, 32'h0000_0008);
        wb(1'h1, 4'hc, 32'hffff_ffff, 4'hf, rd);
        wb(1'h0, 4'hc, 32'h0, 4'hf, rd);
        chk(rd, 32'h0000_0000);
        wb(1'h1, 4'h4, 32'h0000_0008, 4'he, rd);
        wb(1'h0, 4'h4, 32'h0, 4'hf, rd);
        chk(rd, 32'h0000_0000);
        for (int c = 0; c < 8; c++) begin
            {a, p, u} = 3'(c);
            wb(1'h1, 4'h0, {24'h0, 8'hfb | {5'h0, p, 2'h0}}, 4'hf, rd);
            wb(1'h1, 4'h4, {24'h0, 8'hf5 | {4'h0, a, 1'h0, u, 1'h0}}, 4'hf, rd);
            wb(1'h0, 4'h8, 32'h0, 4'hf, rd);
            chk(rd, {28'h0, ~(a & p), a, ~a & p, u});
            chk({28'h0, sector_map_valid, sector_map_index}, {28'h0, ~(a & p), a, ~a & p, u});
            if (!(a && p)) begin
                host.detect(idx, n);
                chk(32'(idx), 32'(c));
                chk(32'(n), 32'h0000_0003);
            end
        end
        n0 = oe_cnt;
        host.xfer(smd_pkg::SMD_CMD_READ_SFDP, 32'h0000_0048, 24, 8, 24, q);
        chk(32'(oe_cnt != n0), 32'h0000_0001);
        for (int w = 0; w < 6; w++) chk(q[191-32*w -: 32], DESC_EXP[191-32*w -: 32]);
        n0 = oe_cnt;
        host.xfer(8'h03, 32'h0000_0004, 32, 4, 1, q);
        chk(32'(oe_cnt - n0), 32'h0000_0000);
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        wb(1'h0, 4'h4, 32'h0, 4'hf, rd);
        chk(rd, 32'h0000_0000);
        wb(1'h0, 4'h8, 32'h0, 4'hf, rd);
        chk(rd, 32'h0000_0008);
        conclude();
    end
endmodule : test_sector_map_detection
